// *** rtl/drive_seq_map.vh ***
// Constants and field map of the drive positioning sequencer
`ifndef DRIVE_SEQ_MAP_VH
`define DRIVE_SEQ_MAP_VH
// Control word bits
`define CB_JOG_UP     0
`define CB_JOG_DN     1
`define CB_TAKE_TGT   2
`define CB_PERMIT     4
`define CB_NO_LOOP    6
`define CB_READJ      10
`define CB_TOGGLE     13
`define CB_ERR_ACK    14
// Status word bits
`define SB_ON_TGT     0
`define SB_TOGGLE     2
`define SB_SUPPLY     4
`define SB_ABORTED    5
`define SB_RUNNING    6
`define SB_REVERSE    8
`define SB_BLOCK      10
`define SB_DISPLACED  11
`define SB_BAD_TGT    12
`define SB_NO_SUPPLY  13
`define STATUS_RST    16'h0100
// Whole control words
`define CW_STOP       16'h0000
`define CW_PERMIT     16'h0010
`define CW_POS        16'h0014
`define CW_JOG_UP     16'h0011
`define CW_JOG_DN     16'h0012
// Position figures in steps (400 steps per rotation)
`define OVERSHOOT     32'h000000FA
`define DEV_LIMIT     32'h00000001
`define UPPER_RST     32'h7FFFFFFF
`define LOWER_RST     32'h80000000
// Blocking: threshold percent and time
`define BLOCK_PCT     16'h001E
`define BLOCK_FRAC    32'h0000028F
`define BLOCK_MS      200
`define CLK_KHZ       10000
`define BLOCK_CYC     (`BLOCK_MS * `CLK_KHZ)
`define CTR_W         24
// Register offsets of the plain port (word index)
`define RA_CTRL       4'h0
`define RA_TARGET     4'h1
`define RA_LOOP       4'h2
`define RA_VMAX_POS   4'h3
`define RA_VMAX_JOG   4'h4
`define RA_ACCEL      4'h5
`define RA_DECEL      4'h6
`define RA_I_START    4'h7
`define RA_I_RUN      4'h8
`define RA_T_START    4'h9
`define RA_WINDOW     4'hA
`define RA_UPPER      4'hB
`define RA_LOWER      4'hC
`define RA_STATUS     4'hD
`define RA_ACTUAL     4'hE
`endif

// *** rtl/drive_positioning_sequencer.v ***
// Run sequencer of a fieldbus positioning drive
`timescale 1ns/1ps
`include "drive_seq_map.vh"
module drive_positioning_sequencer (
   input  wire        clk_i,
   input  wire        nrst_i,
   input  wire        operational_i,
   input  wire        pdo_valid_i,
   input  wire [15:0] pdo_ctrl_i,
   input  wire [31:0] pdo_target_i,
   input  wire [3:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   input  wire [31:0] actual_i,
   input  wire [31:0] encoder_i,
   input  wire [15:0] speed_i,
   input  wire        standstill_i,
   input  wire        supply_ok_i,
   input  wire        at_target_i,
   output reg  [31:0] rdata_o,
   output reg  [31:0] goal_o,
   output reg         move_o,
   output reg  [15:0] vmax_o,
   output reg  [15:0] ramp_o,
   output reg  [15:0] ilimit_o,
   output reg         hold_o,
   output reg  [15:0] status_o
);

   // Sequencer states, one-hot
   localparam [6:0] S_IDLE  = 7'h01;
   localparam [6:0] S_OVER  = 7'h02;
   localparam [6:0] S_APPR  = 7'h04;
   localparam [6:0] S_CHECK = 7'h08;
   localparam [6:0] S_JOG   = 7'h10;
   localparam [6:0] S_BRAKE = 7'h20;
   localparam [6:0] S_DONE  = 7'h40;

   reg [6:0]  state;
   reg [15:0] ctrl;
   reg [31:0] target;
   reg        tgt_valid;
   reg        tgt_new;
   reg [31:0] loop_len;
   reg [15:0] vmax_pos;
   reg [15:0] vmax_jog;
   reg [15:0] accel;
   reg [15:0] decel;
   reg [15:0] i_start;
   reg [15:0] i_run;
   reg [`CTR_W-1:0] t_start;
   reg [31:0] window;
   reg [31:0] upper;
   reg [31:0] lower;
   reg [`CTR_W-1:0] start_cnt;
   reg [`CTR_W-1:0] block_cnt;
   reg        retried;
   reg        looped;
   reg        run_jog;
   reg        settled;
   reg        readj_ok;
   reg        prev_ack;
   reg        prev_permit;
   reg [31:0] rest_pos;

   // Absolute difference of two positions
   function [31:0] absdiff;
      input [31:0] a;
      input [31:0] b;
      begin
         absdiff = ($signed(a) > $signed(b)) ? a - b : b - a;
      end
   endfunction

   // A new control word from either path
   wire        pdo_take  = pdo_valid_i & operational_i;
   wire        sdo_ctrl  = wr_i & (addr_i == `RA_CTRL);
   wire        new_word  = pdo_take | sdo_ctrl;
   wire [15:0] word      = pdo_take ? pdo_ctrl_i : wdata_i[15:0];
   wire        permit    = ctrl[`CB_PERMIT];
   wire        direct    = ctrl[`CB_NO_LOOP] | (loop_len == 32'h00000000);
   wire        loop_neg  = loop_len[31];
   wire [15:0] vsel      = run_jog ? vmax_jog : vmax_pos;
   wire [31:0] spd_lim   = vsel * `BLOCK_PCT;
   wire        slow      = ({speed_i, 16'h0000} < spd_lim * `BLOCK_FRAC);
   wire        moving    = (state != S_IDLE) & (state != S_DONE);
   wire [31:0] dev       = absdiff(actual_i, encoder_i);
   wire [31:0] shift     = absdiff(actual_i, rest_pos);
   // Displacement is measured from where the last good run came to rest
   wire        left_win  = settled & (shift > window);
   wire        against   = loop_neg ? ($signed(actual_i) > $signed(rest_pos))
                                    : ($signed(actual_i) < $signed(rest_pos));
   wire        ack_edge  = ctrl[`CB_ERR_ACK] & ~prev_ack;
   // Target taken with bit 2 from a process object, or written directly
   wire        tgt_pdo   = pdo_take & pdo_ctrl_i[`CB_TAKE_TGT];
   wire        tgt_sdo   = wr_i & (addr_i == `RA_TARGET);
   wire [31:0] new_tgt   = tgt_pdo ? pdo_target_i : wdata_i;
   // Loop mode of the word that carries the target, not of the previous word
   wire        dir_in    = (tgt_pdo ? pdo_ctrl_i[`CB_NO_LOOP] : ctrl[`CB_NO_LOOP]) |
                           (loop_len == 32'h00000000);
   wire        tgt_bad   = (loop_neg & ~dir_in & (new_tgt == upper)) |
                           (~loop_neg & ~dir_in & (new_tgt == lower)) |
                           ($signed(new_tgt) > $signed(upper)) |
                           ($signed(new_tgt) < $signed(lower));
   wire        perm_rise = permit & ~prev_permit;
   // Positioning start: permission rise, or fresh target with permission
   wire        pos_go    = (perm_rise | (tgt_new & permit)) &
                           tgt_valid & ~ctrl[`CB_JOG_UP] & ~ctrl[`CB_JOG_DN];
   wire        jog_go    = permit & (ctrl[`CB_JOG_UP] ^ ctrl[`CB_JOG_DN]);
   wire        behind    = loop_neg ? ($signed(target) > $signed(actual_i))
                                    : ($signed(target) < $signed(actual_i));

   // Register writes and target acceptance
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         ctrl      <= 16'h0000;
         target    <= 32'h00000000;
         tgt_valid <= 1'b0;
         tgt_new   <= 1'b0;
         loop_len  <= 32'h00000000;
         vmax_pos  <= 16'h0000;
         vmax_jog  <= 16'h0000;
         accel     <= 16'h0000;
         decel     <= 16'h0000;
         i_start   <= 16'h0000;
         i_run     <= 16'h0000;
         t_start   <= {`CTR_W{1'b0}};
         window    <= 32'h00000000;
         upper     <= `UPPER_RST;
         lower     <= `LOWER_RST;
      end else begin
         if (new_word) begin
            ctrl <= word;
         end
         // Fresh target starts a run one cycle later, once target and mode bits have landed
         tgt_new <= (tgt_pdo | tgt_sdo) & ~moving & ~tgt_bad;
         if ((tgt_pdo | tgt_sdo) & ~moving & ~tgt_bad) begin
            target    <= new_tgt;
            tgt_valid <= 1'b1;
         end else if ((tgt_pdo | tgt_sdo) & ~moving) begin
            tgt_valid <= 1'b0;
         end
         if (wr_i) begin
            case (addr_i)
               `RA_LOOP:     loop_len <= wdata_i;
               `RA_VMAX_POS: vmax_pos <= wdata_i[15:0];
               `RA_VMAX_JOG: vmax_jog <= wdata_i[15:0];
               `RA_ACCEL:    accel    <= wdata_i[15:0];
               `RA_DECEL:    decel    <= wdata_i[15:0];
               `RA_I_START:  i_start  <= wdata_i[15:0];
               `RA_I_RUN:    i_run    <= wdata_i[15:0];
               `RA_T_START:  t_start  <= wdata_i[`CTR_W-1:0];
               `RA_WINDOW:   window   <= wdata_i;
               `RA_UPPER:    upper    <= wdata_i;
               `RA_LOWER:    lower    <= wdata_i;
               default:      ;
            endcase
         end
      end
   end

   // Run sequencer and status flags
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         state       <= S_IDLE;
         goal_o      <= 32'h00000000;
         move_o      <= 1'b0;
         hold_o      <= 1'b0;
         status_o    <= `STATUS_RST;
         start_cnt   <= {`CTR_W{1'b0}};
         block_cnt   <= {`CTR_W{1'b0}};
         retried     <= 1'b0;
         looped      <= 1'b0;
         run_jog     <= 1'b0;
         settled     <= 1'b0;
         readj_ok    <= 1'b0;
         prev_ack    <= 1'b0;
         prev_permit <= 1'b0;
         rest_pos    <= 32'h00000000;
      end else begin
         prev_ack    <= ctrl[`CB_ERR_ACK];
         prev_permit <= permit;
         status_o[`SB_SUPPLY]  <= supply_ok_i;
         status_o[`SB_RUNNING] <= ~standstill_i;
         if (new_word) begin
            status_o[`SB_TOGGLE] <= word[`CB_TOGGLE];
         end
         if (ack_edge) begin
            status_o[`SB_ABORTED]   <= 1'b0;
            status_o[`SB_BLOCK]     <= 1'b0;
            status_o[`SB_DISPLACED] <= 1'b0;
            status_o[`SB_BAD_TGT]   <= 1'b0;
            status_o[`SB_NO_SUPPLY] <= 1'b0;
         end
         if ((tgt_pdo | tgt_sdo) & ~moving) begin
            status_o[`SB_BAD_TGT] <= tgt_bad;
         end
         // Startup current window and blocking timer
         if (start_cnt != {`CTR_W{1'b0}}) begin
            start_cnt <= start_cnt - 1'b1;
         end
         if (moving & (state != S_BRAKE) & slow & (start_cnt == {`CTR_W{1'b0}})) begin
            block_cnt <= block_cnt + 1'b1;
         end else begin
            block_cnt <= {`CTR_W{1'b0}};
         end
         case (state)
            S_IDLE, S_DONE: begin
               move_o <= 1'b0;
               if (!standstill_i) begin
                  // Wait for standstill before taking a new command
               end else if (jog_go) begin
                  run_jog   <= 1'b1;
                  goal_o    <= ctrl[`CB_JOG_UP] ? upper : lower;
                  move_o    <= 1'b1;
                  hold_o    <= 1'b0;
                  settled   <= 1'b0;
                  readj_ok  <= 1'b0;
                  start_cnt <= t_start;
                  status_o[`SB_ON_TGT]  <= 1'b0;
                  status_o[`SB_ABORTED] <= 1'b0;
                  if (ctrl[`CB_JOG_UP] == loop_neg) begin
                     status_o[`SB_REVERSE] <= 1'b1;
                  end
                  state <= S_JOG;
               end else if (pos_go | (settled & readj_ok & permit & ctrl[`CB_READJ] &
                        left_win & (against | direct) & supply_ok_i)) begin
                  run_jog   <= 1'b0;
                  retried   <= 1'b0;
                  hold_o    <= 1'b0;
                  settled   <= 1'b0;
                  start_cnt <= t_start;
                  status_o[`SB_ON_TGT]    <= 1'b0;
                  status_o[`SB_ABORTED]   <= 1'b0;
                  status_o[`SB_BLOCK]     <= 1'b0;
                  status_o[`SB_DISPLACED] <= 1'b0;
                  status_o[`SB_NO_SUPPLY] <= ~supply_ok_i;
                  move_o    <= 1'b1;
                  looped    <= ~direct;
                  // Loop: back off 5/8 rotation when target behind or after reverse
                  if (~direct & (behind | status_o[`SB_REVERSE])) begin
                     goal_o <= loop_neg ? target + `OVERSHOOT : target - `OVERSHOOT;
                     status_o[`SB_REVERSE] <= 1'b1;
                     state  <= S_OVER;
                  end else begin
                     goal_o <= target;
                     state  <= S_APPR;
                  end
               end else if (settled & left_win & ~(against | direct)) begin
                  status_o[`SB_DISPLACED] <= 1'b1;
                  status_o[`SB_ON_TGT]    <= 1'b0;
                  settled <= 1'b0;
               end else if (settled & readj_ok & permit & ctrl[`CB_READJ] & left_win) begin
                  status_o[`SB_BLOCK]     <= 1'b1;
                  status_o[`SB_NO_SUPPLY] <= 1'b1;
                  settled <= 1'b0;
               end else if (settled & left_win) begin
                  status_o[`SB_DISPLACED] <= 1'b1;
                  status_o[`SB_ON_TGT]    <= 1'b0;
                  settled <= 1'b0;
               end
            end
            S_OVER: begin
               if (at_target_i) begin
                  goal_o <= target;
                  state  <= S_APPR;
               end
            end
            S_APPR: begin
               if (at_target_i) begin
                  move_o <= 1'b0;
                  state  <= S_CHECK;
               end
            end
            S_CHECK: begin
               if (standstill_i) begin
                  if (dev > `DEV_LIMIT) begin
                     if (retried) begin
                        status_o[`SB_BLOCK] <= 1'b1;
                        hold_o <= 1'b1;
                        state  <= S_DONE;
                     end else begin
                        retried <= 1'b1;
                        start_cnt <= t_start;
                        move_o  <= 1'b1;
                        state   <= S_APPR;
                     end
                  end else begin
                     status_o[`SB_ON_TGT] <= 1'b1;
                     if (looped) begin
                        status_o[`SB_REVERSE] <= 1'b0;
                     end
                     settled  <= 1'b1;
                     readj_ok <= 1'b1;
                     rest_pos <= actual_i;
                     hold_o   <= 1'b1;
                     state    <= S_DONE;
                  end
               end
            end
            S_JOG: begin
               if (~jog_go) begin
                  move_o <= 1'b0;
                  state  <= S_BRAKE;
               end
            end
            S_BRAKE: begin
               if (standstill_i) begin
                  hold_o <= 1'b1;
                  state  <= S_DONE;
               end
            end
            default: state <= S_IDLE;
         endcase
         // Permission clear aborts, blocking aborts; both override the sequence
         if (moving & (state != S_BRAKE) & ~permit) begin
            move_o   <= 1'b0;
            readj_ok <= 1'b0;
            if (!run_jog) begin
               status_o[`SB_ABORTED] <= 1'b1;
            end
            state <= S_BRAKE;
         end else if (block_cnt >= `BLOCK_CYC) begin
            move_o   <= 1'b0;
            hold_o   <= 1'b1;
            status_o[`SB_BLOCK] <= 1'b1;
            state    <= S_DONE;
         end
      end
   end

   // Speed, ramp and current selection
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         vmax_o   <= 16'h0000;
         ramp_o   <= 16'h0000;
         ilimit_o <= 16'h0000;
      end else begin
         vmax_o   <= vsel;
         ramp_o   <= move_o ? accel : decel;
         ilimit_o <= (start_cnt != {`CTR_W{1'b0}}) ? i_start : i_run;
      end
   end

   // Read data, one cycle after the strobe
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_o <= 32'h00000000;
      end else if (rd_i) begin
         case (addr_i)
            `RA_CTRL:     rdata_o <= {16'h0000, ctrl};
            `RA_TARGET:   rdata_o <= target;
            `RA_LOOP:     rdata_o <= loop_len;
            `RA_VMAX_POS: rdata_o <= {16'h0000, vmax_pos};
            `RA_VMAX_JOG: rdata_o <= {16'h0000, vmax_jog};
            `RA_ACCEL:    rdata_o <= {16'h0000, accel};
            `RA_DECEL:    rdata_o <= {16'h0000, decel};
            `RA_I_START:  rdata_o <= {16'h0000, i_start};
            `RA_I_RUN:    rdata_o <= {16'h0000, i_run};
            `RA_T_START:  rdata_o <= {{(32-`CTR_W){1'b0}}, t_start};
            `RA_WINDOW:   rdata_o <= window;
            `RA_UPPER:    rdata_o <= upper;
            `RA_LOWER:    rdata_o <= lower;
            `RA_STATUS:   rdata_o <= {16'h0000, status_o};
            `RA_ACTUAL:   rdata_o <= actual_i;
            default:      rdata_o <= 32'h00000000;
         endcase
      end else begin
         rdata_o <= 32'h00000000;
      end
   end

endmodule

// *** verification/motion_stage_model.sv ***
// Behavioural motion stage that follows the sequencer goal and permission
`timescale 1ns/1ps
module motion_stage_model (
   input  wire        clk_i,
   input  wire        nrst_i,
   input  wire        move_i,
   input  wire [31:0] goal_i,
   input  wire [15:0] vmax_i,
   input  wire        push_i,
   input  wire [31:0] push_amt_i,
   input  wire [31:0] enc_off_i,
   output reg  [31:0] actual_o,
   output wire [31:0] encoder_o,
   output wire [15:0] speed_o,
   output wire        standstill_o,
   output wire        at_target_o
);
   wire running;
   // One step a cycle toward the goal while moving is permitted
   assign running = move_i && (actual_o != goal_i);
   always @(posedge clk_i) begin
      if (!nrst_i)
         actual_o <= 32'h00000000;
      else if (push_i)
         actual_o <= actual_o + push_amt_i;  // External turn at standstill
      else if (running)
         actual_o <= ($signed(goal_i) > $signed(actual_o)) ? actual_o + 32'h1 : actual_o - 32'h1;
   end
   // Encoder may be skewed to provoke a final position deviation
   assign encoder_o    = actual_o + enc_off_i;
   assign speed_o      = running ? vmax_i : 16'h0000;
   assign standstill_o = !running;
   assign at_target_o  = (actual_o == goal_i);
endmodule

// *** verification/drive_seq_properties.sv ***
// Port-level assertions for the drive positioning sequencer
`timescale 1ns/1ps
`include "drive_seq_map.vh"
module drive_seq_checker (
   input wire        clk_i,
   input wire        nrst_i,
   input wire        operational_i,
   input wire        pdo_valid_i,
   input wire [15:0] pdo_ctrl_i,
   input wire [3:0]  addr_i,
   input wire [31:0] wdata_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire        standstill_i,
   input wire [31:0] rdata_o,
   input wire        move_o,
   input wire [15:0] ramp_o,
   input wire [15:0] ilimit_o,
   input wire [15:0] status_o
);
   reg  [15:0] acc, dec, i_st, i_run, t_st, mv_cnt;
   reg         seen, jog_mode;
   wire        cmd, stop;
   // Shadow ramp and current settings, count cycles of each move
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         seen   <= 1'h0;
         jog_mode <= 1'h0;
         mv_cnt <= 16'h0000;
      end else begin
         mv_cnt <= move_o ? mv_cnt + 16'h0001 : 16'h0000;
         seen   <= seen | (wr_i && addr_i == `RA_T_START);
         // A jog stop is not a positioning abort
         if (cmd) begin
            jog_mode <= pdo_ctrl_i[`CB_JOG_UP] ^ pdo_ctrl_i[`CB_JOG_DN];
         end
         if (wr_i) begin
            case (addr_i)
               `RA_ACCEL:   acc   <= wdata_i[15:0];
               `RA_DECEL:   dec   <= wdata_i[15:0];
               `RA_I_START: i_st  <= wdata_i[15:0];
               `RA_I_RUN:   i_run <= wdata_i[15:0];
               `RA_T_START: t_st  <= wdata_i[15:0];
               default:     ;
            endcase
         end
      end
   end
   // Accepted process objects and stop words
   assign cmd  = pdo_valid_i && operational_i;
   assign stop = cmd && pdo_ctrl_i == `CW_STOP;
   default clocking dcb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_rdata_idle:
      assert property (!rd_i |=> rdata_o == 32'h00000000) else $error("read data not idle");
   a_toggle_copy:
      assert property (cmd |-> ##1 status_o[`SB_TOGGLE] == $past(pdo_ctrl_i[`CB_TOGGLE]))
      else $error("toggle bit not copied");
   a_nonop_ignored:
      assert property ((pdo_valid_i && !operational_i) |-> ##2
         status_o[`SB_TOGGLE] == $past(status_o[`SB_TOGGLE], 2)) else $error("word taken offline");
   a_stop_halts:
      assert property (stop |-> ##[1:3] !move_o) else $error("stop word did not halt");
   a_abort_flag:
      assert property ((stop && move_o && !jog_mode) |-> ##[1:3] status_o[`SB_ABORTED])
      else $error("abort flag missing");
   a_ramp_run:
      assert property (move_o[*3] ##0 seen |-> ramp_o == acc) else $error("ramp not accel");
   a_ramp_idle:
      assert property ((!move_o)[*3] ##0 seen |-> ramp_o == dec) else $error("ramp not decel");
   a_start_current:
      assert property ((seen && move_o && mv_cnt == 16'h0002) |-> ilimit_o == i_st)
      else $error("start current not applied");
   a_run_current:
      assert property ((seen && move_o && mv_cnt == t_st + 16'h0004) |-> ilimit_o == i_run)
      else $error("run current not applied");
   a_block_stops:
      assert property ($rose(status_o[`SB_BLOCK]) |-> ##[0:2] !move_o)
      else $error("moving after block");
   a_target_still:
      assert property ($rose(status_o[`SB_ON_TGT]) |-> !move_o && standstill_i)
      else $error("on target while moving");
   c_run:   cover property ($rose(move_o));
   c_abort: cover property ($rose(status_o[`SB_ABORTED]));
   c_block: cover property ($rose(status_o[`SB_BLOCK]));
endmodule
bind drive_positioning_sequencer drive_seq_checker u_chk (
   .clk_i(clk_i), .nrst_i(nrst_i), .operational_i(operational_i), .pdo_valid_i(pdo_valid_i),
   .pdo_ctrl_i(pdo_ctrl_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .standstill_i(standstill_i), .rdata_o(rdata_o), .move_o(move_o), .ramp_o(ramp_o),
   .ilimit_o(ilimit_o), .status_o(status_o));

// *** verification/test_drive_positioning_sequencer.sv ***
// Self-checking bench for the drive positioning sequencer
`timescale 1ns/1ps
`include "drive_seq_map.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_drive_positioning_sequencer;
   reg         clk_i, nrst_i, operational_i, pdo_valid_i, wr_i, rd_i, supply_ok_i, push;
   reg  [15:0] pdo_ctrl_i;
   reg  [31:0] pdo_target_i, wdata_i, push_amt, enc_off, pos0;
   reg  [3:0]  addr_i;
   wire [31:0] rdata_o, goal_o, actual_i, encoder_i;
   wire [15:0] vmax_o, ramp_o, ilimit_o, status_o, speed_i;
   wire        move_o, hold_o, standstill_i, at_target_i;
   int         err_total, check_count, i;
   drive_positioning_sequencer u_dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .operational_i(operational_i),
      .pdo_valid_i(pdo_valid_i), .pdo_ctrl_i(pdo_ctrl_i), .pdo_target_i(pdo_target_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .actual_i(actual_i),
      .encoder_i(encoder_i), .speed_i(speed_i), .standstill_i(standstill_i),
      .supply_ok_i(supply_ok_i), .at_target_i(at_target_i), .rdata_o(rdata_o),
      .goal_o(goal_o), .move_o(move_o), .vmax_o(vmax_o), .ramp_o(ramp_o),
      .ilimit_o(ilimit_o), .hold_o(hold_o), .status_o(status_o));
   motion_stage_model u_stage (
      .clk_i(clk_i), .nrst_i(nrst_i), .move_i(move_o), .goal_i(goal_o), .vmax_i(vmax_o),
      .push_i(push), .push_amt_i(push_amt), .enc_off_i(enc_off), .actual_o(actual_i),
      .encoder_o(encoder_i), .speed_o(speed_i), .standstill_o(standstill_i),
      .at_target_o(at_target_i));
   // Register port write
   task reg_wr(input [3:0] a, input [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'h1;
      @(posedge clk_i);
      wr_i    <= 1'h0;
   endtask
   // Register port read, data taken in the answer cycle
   task reg_rd(input [3:0] a, input [31:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'h1;
      @(posedge clk_i);
      rd_i   <= 1'h0;
      @(posedge clk_i);
      `CHK(rdata_o, e)
   endtask
   // Process object, then a short settling gap
   task pdo(input [15:0] c, input [31:0] t);
      @(posedge clk_i);
      pdo_ctrl_i   <= c;
      pdo_target_i <= t;
      pdo_valid_i  <= 1'h1;
      @(posedge clk_i);
      pdo_valid_i  <= 1'h0;
      repeat (3) @(posedge clk_i);
   endtask
   // External turn of the shaft at standstill
   task shift(input [31:0] d);
      @(posedge clk_i);
      push     <= 1'h1;
      push_amt <= d;
      @(posedge clk_i);
      push     <= 1'h0;
   endtask
   // Bounded wait on a status bit, or on move_o when n is 16
   task wait_for(input int n, input logic lvl);
      int k;
      k = 0;
      while (((n == 16) ? move_o : status_o[n]) !== lvl && k < 4000) begin
         @(posedge clk_i);
         k++;
      end
      `CHK(((n == 16) ? move_o : status_o[n]), lvl)
   endtask
   // Follow a positioning run from first goal to final position
   task follow(input [31:0] g, input [31:0] f);
      wait_for(16, 1'h1);
      `CHK(goal_o, g)
      `CHK(vmax_o, 16'h0064)
      wait_for(`SB_ON_TGT, 1'h1);
      `CHK(actual_i, f)
   endtask
   task stop_test;
      $display("errors %0d of %0d checks", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Clock and watchdog
   initial begin
      clk_i = 1'h0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      stop_test;
   end
   // Main sequence
   initial begin
      {nrst_i, operational_i, pdo_valid_i, wr_i, rd_i, push} = 6'h00;
      supply_ok_i = 1'h1;
      {pdo_ctrl_i, addr_i} = 20'h00000;
      {pdo_target_i, wdata_i, push_amt, enc_off} = 128'h0;
      err_total = 0;
      check_count = 0;
      repeat (16) @(posedge clk_i);
      `CHK(status_o, 16'h0100)
      nrst_i <= 1'h1;
      reg_wr(`RA_LOOP, 32'h10);
      reg_wr(`RA_VMAX_POS, 32'h64);
      reg_wr(`RA_VMAX_JOG, 32'h32);
      reg_wr(`RA_ACCEL, 32'h5);
      reg_wr(`RA_DECEL, 32'h7);
      reg_wr(`RA_I_START, 32'h20);
      reg_wr(`RA_I_RUN, 32'h10);
      reg_wr(`RA_T_START, 32'h8);
      reg_wr(`RA_WINDOW, 32'h2);
      reg_wr(`RA_UPPER, 32'h1000);
      reg_wr(`RA_LOWER, 32'hFFFFF000);
      reg_rd(`RA_VMAX_POS, 32'h64);
      reg_rd(4'hF, 32'h0);
      pdo(16'h2014, 32'h64);
      `CHK(move_o, 1'h0)
      operational_i <= 1'h1;
      pdo(16'h2014, 32'h64);
      follow(32'hFFFFFF6A, 32'h64);
      `CHK(status_o[`SB_TOGGLE], 1'h1)
      reg_wr(`RA_CTRL, `CW_STOP);
      reg_wr(`RA_TARGET, 32'h32);
      reg_wr(`RA_CTRL, 32'h10);
      follow(32'hFFFFFF38, 32'h32);
      pdo(16'h0054, 32'h14);
      follow(32'h14, 32'h14);
      pdo(`CW_POS, 32'hFFFFF000);
      `CHK(status_o[`SB_BAD_TGT], 1'h1)
      `CHK(move_o, 1'h0)
      pdo(`CW_POS, 32'h12C);
      wait_for(16, 1'h1);
      repeat (10) @(posedge clk_i);
      pdo(`CW_POS, 32'h28);
      `CHK(goal_o, 32'h12C)
      pdo(`CW_STOP, 32'h0);
      `CHK(move_o, 1'h0)
      `CHK(status_o[`SB_ABORTED], 1'h1)
      wait_for(`SB_RUNNING, 1'h0);
      pdo(16'h0004, 32'h96);
      `CHK(move_o, 1'h0)
      pdo(16'h0050, 32'h3E7);
      follow(32'h96, 32'h96);
      pdo(16'h0414, 32'hAA);
      follow(32'hAA, 32'hAA);
      shift(32'hFFFFFFFB);
      wait_for(16, 1'h1);
      wait_for(`SB_ON_TGT, 1'h1);
      `CHK(actual_i, 32'hAA)
      shift(32'h5);
      repeat (10) @(posedge clk_i);
      `CHK(move_o, 1'h0)
      `CHK(status_o[`SB_DISPLACED], 1'h1)
      `CHK(status_o[`SB_ON_TGT], 1'h0)
      enc_off <= 32'h5;
      pdo(16'h0414, 32'hC8);
      wait_for(`SB_BLOCK, 1'h1);
      `CHK(hold_o, 1'h1)
      `CHK(status_o[`SB_ON_TGT], 1'h0)
      enc_off <= 32'h0;
      pdo(16'h0414, 32'hB4);
      follow(32'hFFFFFFBA, 32'hB4);
      `CHK(status_o[`SB_BLOCK], 1'h0)
      supply_ok_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      `CHK(status_o[`SB_SUPPLY], 1'h0)
      shift(32'hFFFFFFFB);
      repeat (5) @(posedge clk_i);
      `CHK(status_o[`SB_BLOCK], 1'h1)
      `CHK(status_o[`SB_NO_SUPPLY], 1'h1)
      supply_ok_i <= 1'h1;
      repeat (20) @(posedge clk_i);
      `CHK(move_o, 1'h0)
      for (i = 0; i < 2; i++) begin
         pdo(i ? `CW_JOG_DN : `CW_JOG_UP, 32'h0);
         wait_for(16, 1'h1);
         `CHK(vmax_o, 16'h0032)
         pos0 = actual_i;
         repeat (20) @(posedge clk_i);
         `CHK($signed(actual_i) > $signed(pos0), i == 0)
         pdo(i ? `CW_STOP : 16'h0010, 32'h0);
         wait_for(16, 1'h0);
         wait_for(`SB_RUNNING, 1'h0);
      end
      stop_test;
   end
endmodule
